/* File: tb/ccr_board.sv */
/* Board model: ratio straps, board reset source, reset-done loop.
   Assumes the bench changes straps only while rstn_i is low. */
`timescale 1ns/1ps
module ccr_board #(
  parameter int DLY = 37 // Reset path skew, ns, off the clock edge
) (
  // Requests from the bench
  input  wire logic [2:0] strap_i,
  input  wire logic       rst_req_i,
  // Device reset-done
  input  wire logic       reset_done_i,
  // Board pins
  output logic [2:0]      straps_o,
  output logic            reset_in_n_o,
  output logic            dram_por_n_o
);
  // Straps only move across a power cycle
  assign straps_o = strap_i;
  // Asynchronous board reset, skewed from the clock
  assign #(DLY) reset_in_n_o = !rst_req_i;
  // Reset-done wired straight to the DRAM reset
  assign dram_por_n_o = reset_done_i;
endmodule

/* File: tb/ccr_top_asserts.sv */
/* Checker for ccr_top: reset hold, pin release, ratio and tick spacing.
   Assumes one clk_i domain with synchronous active-low rstn_i. */
`timescale 1ns/1ps
`include "ccr_cfg.svh"
module ccr_top_asserts (
  // Clock and reset
  input wire logic                  clk_i,
  input wire logic                  rstn_i,
  // Board pins
  input wire logic [2:0]            core_ratio_straps_i,
  input wire logic                  reset_in_n_i,
  // Outputs watched
  input wire logic [`CCR_PIN_W-1:0] pin_oe_o,
  input wire logic                  reset_done_o,
  input wire logic [3:0]            core_ratio_o,
  input wire logic                  ratio_reserved_o,
  input wire logic                  core_idle_o,
  input wire logic                  dram_ready_o,
  input wire logic                  core_instruction_clock_tick_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Ratio per code, one nibble each; reserved reads as 4
  localparam logic [31:0] RTAB = 32'h4CA87654;
  logic [4:0] in_cnt; // Cycles reset input high, saturating
  logic [4:0] gap;    // Cycles since last tick
  logic       tseen;  // First tick of a run has no reference
  // Count how long the board reset has been released
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !reset_in_n_i) in_cnt <= 5'h00;
    else if (in_cnt != 5'h1F) in_cnt <= in_cnt + 5'h01;
  end
  // Spacing between ticks, restarted at each run
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !reset_done_o) begin
      gap   <= 5'h01;
      tseen <= 1'b0;
    end else if (core_instruction_clock_tick_o) begin
      gap   <= 5'h01;
      tseen <= 1'b1;
    end else if (gap != 5'h1F) gap <= gap + 5'h01;
  end
  sequence s_in_low; !reset_in_n_i [*4]; endsequence
  sequence s_ready_up; $rose(dram_ready_o); endsequence
  property p_hold; s_in_low |-> core_idle_o && !reset_done_o; endproperty
  a_hold: assert property (p_hold) else $error("core not idle in reset");
  property p_oe; !reset_done_o |-> pin_oe_o == '0; endproperty
  a_oe: assert property (p_oe) else $error("pin driven in reset");
  property p_idle; core_idle_o != reset_done_o; endproperty
  a_idle: assert property (p_idle) else $error("idle and done disagree");
  property p_wait; $rose(reset_done_o) |-> in_cnt >= 5'h10; endproperty
  a_wait: assert property (p_wait) else $error("done too early");
  property p_soon; in_cnt == 5'h1C |-> reset_done_o; endproperty
  a_soon: assert property (p_soon) else $error("done too late");
  property p_ratio; reset_done_o |-> core_ratio_o == RTAB[{core_ratio_straps_i, 2'h0} +: 4];
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio wrong");
  property p_rsvd; reset_done_o |-> ratio_reserved_o == (core_ratio_straps_i == 3'h7);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved flag wrong");
  property p_tick;
    core_instruction_clock_tick_o |-> reset_done_o && (!tseen || gap == {1'b0, core_ratio_o});
  endproperty
  a_tick: assert property (p_tick) else $error("tick spacing wrong");
  property p_dram; s_ready_up |-> $past(reset_done_o, 8) && reset_done_o; endproperty
  a_dram: assert property (p_dram) else $error("dram ready early");
endmodule
bind ccr_top ccr_top_asserts u_ccr_top_asserts (.clk_i, .rstn_i, .core_ratio_straps_i,
  .reset_in_n_i, .pin_oe_o, .reset_done_o, .core_ratio_o, .ratio_reserved_o,
  .core_idle_o, .dram_ready_o, .core_instruction_clock_tick_o);

/* File: tb/tb_top.sv */
/* Self-checking bench for ccr_top over every strap code.
   Assumes the board model and the bound checker. */
`timescale 1ns/1ps
`include "ccr_cfg.svh"
module tb_top;
  logic                  clk_i = 1'b0; // System clock
  logic                  rstn_i = 1'b0; // Power cycle
  logic [2:0]            strap = 3'h0; // Code asked of board
  logic                  rst_req = 1'b1; // Board reset request
  logic [`CCR_PIN_W-1:0] pout = '0; // Core pin values
  logic [`CCR_PIN_W-1:0] poe = '0; // Core pin enables
  logic [`CCR_PIN_W-1:0] pin_out;
  logic [`CCR_PIN_W-1:0] pin_oe;
  logic [2:0]            straps;
  logic [3:0]            ratio;
  logic                  reset_in_n, dram_por_n, done, rsvd, idle, dram_rdy, tick;
  int                    errors = 0;
  int                    cmp_count = 0;
  ccr_board u_ccr_board (.strap_i(strap), .rst_req_i(rst_req), .reset_done_i(done),
    .straps_o(straps), .reset_in_n_o(reset_in_n), .dram_por_n_o(dram_por_n));
  ccr_top u_ccr_top (.clk_i(clk_i), .rstn_i(rstn_i), .core_ratio_straps_i(straps),
    .reset_in_n_i(reset_in_n), .dram_por_n_i(dram_por_n), .core_pin_out_i(pout),
    .core_pin_oe_i(poe), .pin_out_o(pin_out), .pin_oe_o(pin_oe), .reset_done_o(done),
    .core_ratio_o(ratio), .ratio_reserved_o(rsvd), .core_idle_o(idle),
    .dram_ready_o(dram_rdy), .core_instruction_clock_tick_o(tick));
  // 10 MHz clock
  initial forever #50 clk_i = ~clk_i;
  // Random core pin traffic every cycle
  always @(posedge clk_i) begin
    pout <= `CCR_PIN_W'($urandom);
    poe  <= `CCR_PIN_W'($urandom);
  end
  // Ratio per code, one nibble each
  function automatic logic [3:0] exp_ratio(input logic [2:0] s);
    logic [31:0] t;
    t = 32'h4CA87654 >> {s, 2'h0};
    return t[3:0];
  endfunction
  task automatic chk(input string nm, input logic [7:0] ev, input logic [7:0] got);
    cmp_count++;
    if (got !== ev) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ev, got);
    end
  endtask
  // Let edges pass, then sample settled outputs
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      step(1);
      n++;
    end while (tick !== 1'b1 && n < 40);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard, well past eight tests
  initial begin
    #(3000 * 100);
    errors++;
    print_verdict();
  end
  // Main sequence: one power cycle per strap code
  initial begin
    int         n;
    logic [7:0] e;
    logic [7:0] f;
    logic [2:0] s;
    void'($urandom(40));
    for (int k = 0; k < 8; k++) begin
      s = 3'(k);
      @(posedge clk_i);
      rstn_i <= 1'b0;
      rst_req <= 1'b1;
      strap <= s;
      repeat (k == 0 ? 20 : 3) @(posedge clk_i);
      rstn_i <= 1'b1;
      step($urandom_range(6, 2));
      chk("idle", 8'h01, {7'h0, idle});
      chk("oe held", 8'h00, pin_oe);
      @(posedge clk_i);
      rst_req <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 40) begin
        step(1);
        n++;
      end
      chk("done", 8'h01, {7'h0, done});
      chk("wait", 8'h01, 8'(n >= 17));
      chk("ratio", {4'h0, exp_ratio(s)}, {4'h0, ratio});
      chk("reserved", 8'(s == 3'h7), {7'h0, rsvd});
      chk("run", 8'h00, {7'h0, idle});
      wait_tick(n);
      wait_tick(n);
      chk("tick gap", {4'h0, exp_ratio(s)}, 8'(n));
      e = poe;
      f = pout;
      step(1);
      chk("oe", e, pin_oe);
      chk("out", f, pin_out);
      step(12);
      chk("dram", 8'h01, {7'h0, dram_rdy});
      @(posedge clk_i);
      rst_req <= 1'b1;
      step(6);
      chk("released", 8'h00, pin_oe);
      chk("done off", 8'h00, {7'h0, done});
      $display("test %0d strap %0d done", k, s);
    end
    print_verdict();
  end
endmodule

/* File: verilog/ccr_cfg.svh */
/*
  Timing counts, strap codes and ratio values for the core clock ratio
  and reset sequencer. Included by ccr_top, the bound checker and the bench.
*/
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

// Clock period in ns
`define CCR_CLK_PERIOD_NS 100
// Internal initialisation time after reset release, ns
`define CCR_INIT_TIME_NS  1600
// Initialisation count in cycles, rounded up
`define CCR_INIT_CYCLES   ((`CCR_INIT_TIME_NS + `CCR_CLK_PERIOD_NS - 1) / `CCR_CLK_PERIOD_NS)
// DRAM power-on initialisation time, ns
`define CCR_DRAM_TIME_NS  800
`define CCR_DRAM_CYCLES   ((`CCR_DRAM_TIME_NS + `CCR_CLK_PERIOD_NS - 1) / `CCR_CLK_PERIOD_NS)
// Strap codes
`define CCR_STRAP_X4      3'h0
`define CCR_STRAP_X5      3'h1
`define CCR_STRAP_X6      3'h2
`define CCR_STRAP_X7      3'h3
`define CCR_STRAP_X8      3'h4
`define CCR_STRAP_X10     3'h5
`define CCR_STRAP_X12     3'h6
`define CCR_STRAP_RSVD    3'h7
// Ratio values
`define CCR_RATIO_4       4'h4
`define CCR_RATIO_5       4'h5
`define CCR_RATIO_6       4'h6
`define CCR_RATIO_7       4'h7
`define CCR_RATIO_8       4'h8
`define CCR_RATIO_10      4'hA
`define CCR_RATIO_12      4'hC
// Output pin count
`define CCR_PIN_W         8

`endif

/* File: verilog/ccr_pkg.sv */
/*
  Types for the core clock ratio and reset sequencer.
  Assumes ccr_cfg.svh is on the include path.
*/
package ccr_pkg;
  // Reset sequencer states, Gray coded along the path
  typedef enum logic [1:0] {
    CCR_HOLD = 2'h0,
    CCR_INIT = 2'h1,
    CCR_RUN  = 2'h3
  } ccr_state_t;
endpackage

/* File: verilog/ccr_sync.sv */
/*
  Two flip-flop synchroniser for an asynchronous level input.
  Assumes the input may change at any time relative to clk_i.
*/
`timescale 1ns/1ps
module ccr_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Level in and out
  input  wire logic d_i,
  output logic      q_o
);
  // First stage, read only by the second
  logic meta;

  // Two stages; reset value given by caller's intent (low)
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

/* File: verilog/ccr_top.sv */
/*
  Core clock ratio selection and reset sequencing.
  Straps pick the core clock multiple of the system clock; a reset input
  holds the core idle and all output pins released; a reset-done output
  goes high after initialisation.
  Assumes clk_i is the system clock, straps are static, and reset_done_o
  is wired back to dram_por_n_i on the board.
*/
// How it works
// R1: Core clock runs at strap-chosen multiple.
// R2: Codes 0-6 give 4,5,6,7,8,10,12; 7 reserved.
// R3: Board keeps straps constant while powered.
// R4: Reset puts logic idle and defined.
// R5: Reset-done output marks sequence complete.
// R6: Board wires reset-done to DRAM reset.
// R7: All output pins released during reset.
// R8: Asynchronous inputs pass a synchroniser first.
// R9: Reset-done waits for release and initialisation.
`timescale 1ns/1ps
`include "ccr_cfg.svh"
module ccr_top (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  // Board pins
  input  wire logic [2:0]           core_ratio_straps_i,
  input  wire logic                 reset_in_n_i,
  input  wire logic                 dram_por_n_i,
  // Core side
  input  wire logic [`CCR_PIN_W-1:0] core_pin_out_i,
  input  wire logic [`CCR_PIN_W-1:0] core_pin_oe_i,
  // Output pins
  output logic [`CCR_PIN_W-1:0]     pin_out_o,
  output logic [`CCR_PIN_W-1:0]     pin_oe_o,
  // Status
  output logic                      reset_done_o,
  output logic [3:0]                core_ratio_o,
  output logic                      ratio_reserved_o,
  output logic                      core_idle_o,
  output logic                      dram_ready_o,
  output logic                      core_instruction_clock_tick_o
);

  // Maps a strap code to its ratio; reserved falls back to 4
  function automatic logic [3:0] ratio_of(input logic [2:0] code);
    case (code)
      `CCR_STRAP_X4:  ratio_of = `CCR_RATIO_4;
      `CCR_STRAP_X5:  ratio_of = `CCR_RATIO_5;
      `CCR_STRAP_X6:  ratio_of = `CCR_RATIO_6;
      `CCR_STRAP_X7:  ratio_of = `CCR_RATIO_7;
      `CCR_STRAP_X8:  ratio_of = `CCR_RATIO_8;
      `CCR_STRAP_X10: ratio_of = `CCR_RATIO_10;
      `CCR_STRAP_X12: ratio_of = `CCR_RATIO_12;
      default:        ratio_of = `CCR_RATIO_4;
    endcase
  endfunction

  localparam int INIT_N = `CCR_INIT_CYCLES;
  localparam int DRAM_N = `CCR_DRAM_CYCLES;

  // Synchronised reset and DRAM reset levels
  logic       rst_in_n_s;
  logic       por_n_s;
  // Synchronised straps, one synchroniser per bit
  logic [2:0] straps_s;
  // Sequencer state
  ccr_pkg::ccr_state_t state;
  ccr_pkg::ccr_state_t next_state;
  // Initialisation counter
  logic [7:0] init_cnt;
  // Straps captured once after reset release
  logic [2:0] strap_lat;
  logic       strap_taken;
  // Core tick phase counter
  logic [3:0] phase;
  // DRAM init counter
  logic [7:0] dram_cnt;

  // Reset and DRAM reset pass a synchroniser
  ccr_sync u_sync_rst ( // R8
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (reset_in_n_i),
    .q_o    (rst_in_n_s)
  );
  ccr_sync u_sync_por ( // R8
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (dram_por_n_i),
    .q_o    (por_n_s)
  );

  // Straps are static, but synchronise anyway for safety
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_strap
      ccr_sync u_sync_strap (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .d_i    (core_ratio_straps_i[gi]),
        .q_o    (straps_s[gi])
      );
    end
  endgenerate

  // Latch straps once; later changes are ignored since they must not move
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      strap_lat   <= `CCR_STRAP_X4;
      strap_taken <= 1'b0;
    end else if (!strap_taken && state == ccr_pkg::CCR_INIT) begin
      strap_lat   <= straps_s; // R3
      strap_taken <= 1'b1;
    end
  end

  // Next state of the reset sequencer
  always_comb begin
    next_state = state;
    case (state)
      ccr_pkg::CCR_HOLD: begin
        if (rst_in_n_s) begin
          next_state = ccr_pkg::CCR_INIT;
        end
      end
      ccr_pkg::CCR_INIT: begin
        if (!rst_in_n_s) begin
          next_state = ccr_pkg::CCR_HOLD;
        end else if (init_cnt == 8'(INIT_N - 1)) begin
          next_state = ccr_pkg::CCR_RUN; // R9
        end
      end
      ccr_pkg::CCR_RUN: begin
        if (!rst_in_n_s) begin
          next_state = ccr_pkg::CCR_HOLD; // R4
        end
      end
      default: next_state = ccr_pkg::CCR_HOLD;
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= ccr_pkg::CCR_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Initialisation counter runs only in INIT
  always_ff @(posedge clk_i) begin
    if (!rstn_i || state != ccr_pkg::CCR_INIT) begin
      init_cnt <= 8'h00;
    end else begin
      init_cnt <= init_cnt + 8'h01;
    end
  end

  // Reset-done goes high only in RUN
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      reset_done_o <= 1'b0;
    end else begin
      reset_done_o <= (next_state == ccr_pkg::CCR_RUN); // R5 R9
    end
  end

  // Core idle while not running
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      core_idle_o <= 1'b1;
    end else begin
      core_idle_o <= (next_state != ccr_pkg::CCR_RUN); // R4
    end
  end

  // Ratio status from the captured straps
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      core_ratio_o     <= `CCR_RATIO_4;
      ratio_reserved_o <= 1'b0;
    end else begin
      core_ratio_o     <= ratio_of(strap_lat); // R2
      ratio_reserved_o <= (strap_lat == `CCR_STRAP_RSVD); // R2
    end
  end

  // Tick once per ratio cycles; one tick stands for ratio core cycles,
  // since the real core clock is faster than anything modelled here.
  // Also stopped on the leaving edge, so no tick follows reset-done low
  always_ff @(posedge clk_i) begin
    if (!rstn_i || state != ccr_pkg::CCR_RUN || next_state != ccr_pkg::CCR_RUN) begin
      phase                         <= 4'h0;
      core_instruction_clock_tick_o <= 1'b0;
    end else if (phase == core_ratio_o - 4'h1) begin
      phase                         <= 4'h0;
      core_instruction_clock_tick_o <= 1'b1; // R1
    end else begin
      phase                         <= phase + 4'h1;
      core_instruction_clock_tick_o <= 1'b0;
    end
  end

  // DRAM initialises after its power-on reset is released
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !por_n_s) begin
      dram_cnt     <= 8'h00;
      dram_ready_o <= 1'b0;
    end else if (dram_cnt == 8'(DRAM_N - 1)) begin
      dram_ready_o <= 1'b1; // R6
    end else begin
      dram_cnt     <= dram_cnt + 8'h01;
    end
  end

  // Output pins released while not running
  always_ff @(posedge clk_i) begin
    if (!rstn_i || next_state != ccr_pkg::CCR_RUN) begin
      pin_oe_o  <= '0; // R7
      pin_out_o <= '0;
    end else begin
      pin_oe_o  <= core_pin_oe_i;
      pin_out_o <= core_pin_out_i;
    end
  end

endmodule
